// ### byte_core_pkg.sv
// shared constants, opcodes and carrier types for the instruction execute block
package byte_core_pkg;

   localparam int INSTR_W   = 14;
   localparam int DATA_W    = 8;
   localparam int FADDR_W   = 7;
   localparam int PC_W      = 13;
   localparam int JUMP_W    = 11;

   // field positions inside a 14-bit instruction word and, for HI_LATCH_LSB, inside the high latch
   localparam int DEST_POS     = 7;
   localparam int BIT_LSB      = 7;
   localparam int HI_LATCH_LSB = 3;

   // instruction cycle: 10 MHz core clock, one instruction cycle of four clocks
   localparam int CLK_HZ          = 10_000_000;
   localparam int CLKS_PER_CYCLE  = 4;

   // opcode patterns (upper bits) and masks
   localparam logic [13:0] OP_ADD_ACC_AND_REGISTER_MASK = 14'h3F00;
   localparam logic [13:0] OP_ADD_REG    = 14'h0700;
   localparam logic [13:0] OP_AND_REG    = 14'h0500;
   localparam logic [13:0] OP_OR_REG     = 14'h0400;
   localparam logic [13:0] OP_MOVE_REG   = 14'h0800;
   localparam logic [13:0] OP_INC_REG    = 14'h0A00;
   localparam logic [13:0] OP_DECSKIP    = 14'h0B00;
   localparam logic [13:0] OP_INCSKIP    = 14'h0F00;
   localparam logic [13:0] STORE_MASK    = 14'h3F80;
   localparam logic [13:0] OP_STORE      = 14'h0080;
   localparam logic [13:0] BIT_MASK      = 14'h3C00;
   localparam logic [13:0] OP_BITCLR     = 14'h1000;
   localparam logic [13:0] OP_BITSET     = 14'h1400;
   localparam logic [13:0] OP_BITTEST    = 14'h1800;
   localparam logic [13:0] JUMP_MASK     = 14'h3800;
   localparam logic [13:0] OP_JUMP       = 14'h2800;
   localparam logic [13:0] LIT_MASK      = 14'h3C00;
   localparam logic [13:0] OP_LOAD_LIT   = 14'h3000;
   localparam logic [13:0] LITX_MASK     = 14'h3F00;
   localparam logic [13:0] OP_OR_LIT     = 14'h3800;
   localparam logic [13:0] OP_AND_LIT    = 14'h3900;
   localparam logic [13:0] ADD_LIT_MASK  = 14'h3E00;
   localparam logic [13:0] OP_ADD_LIT    = 14'h3E00;

   // reset values
   localparam logic [7:0]  ACC_RST = 8'h00;
   localparam logic [12:0] PC_RST  = 13'h0000;

   typedef enum logic [3:0] {
      ALU_NOP    = 4'h0,
      ALU_ADD    = 4'h1,
      ALU_AND    = 4'h2,
      ALU_OR     = 4'h3,
      ALU_PASS_F = 4'h4,
      ALU_INC    = 4'h5,
      ALU_DEC    = 4'h6,
      ALU_PASS_K = 4'h7,
      ALU_BITCLR = 4'h8,
      ALU_BITSET = 4'h9
   } alu_op_t;

   // decoded instruction fields
   typedef struct packed {
      alu_op_t     op;
      logic        use_lit;   // b operand is the immediate
      logic        to_reg;    // result goes to the register
      logic        to_acc;    // result goes to the accumulator
      logic        upd_z;
      logic        upd_cdc;
      logic        skip_zero; // skip when result is zero
      logic        skip_bit;  // skip when tested bit is clear
      logic        jump;
      logic        store;     // accumulator to register
      logic [6:0]  faddr;
      logic [2:0]  bitsel;
      logic [7:0]  lit;
      logic [10:0] target;
   } dec_t;

   // write request to the register file
   typedef struct packed {
      logic       en;
      logic [6:0] addr;
      logic [7:0] data;
   } reg_wr_t;

   // status flags
   typedef struct packed {
      logic z;
      logic half_carry_flag;
      logic c;
   } flags_t;

endpackage : byte_core_pkg

// ### instr_decode.sv
// combinational decoder from instruction word to execute controls
`timescale 1ns/1ps
module instr_decode
   import byte_core_pkg::*;
(
   input  wire logic [13:0] i_instr, // fetched instruction word
   output dec_t             o_dec    // decoded controls
);

   function automatic logic hit(input logic [13:0] w, input logic [13:0] m, input logic [13:0] p);
      return (w & m) == p;
   endfunction : hit

   // classify the word; anything unrecognised behaves as no-operation
   always_comb begin
      logic d;
      d = i_instr[DEST_POS];
      o_dec = '0;
      o_dec.op     = ALU_NOP;
      o_dec.faddr  = i_instr[6:0];
      o_dec.bitsel = i_instr[9:7];
      o_dec.lit    = i_instr[7:0];
      o_dec.target = i_instr[10:0];
      if (hit(i_instr, ADD_LIT_MASK, OP_ADD_LIT)) begin
         o_dec.op = ALU_ADD; o_dec.use_lit = 1'b1; o_dec.to_acc = 1'b1;
         o_dec.upd_z = 1'b1; o_dec.upd_cdc = 1'b1;
      end else if (hit(i_instr, LITX_MASK, OP_AND_LIT)) begin
         o_dec.op = ALU_AND; o_dec.use_lit = 1'b1; o_dec.to_acc = 1'b1;
         o_dec.upd_z = 1'b1;
      end else if (hit(i_instr, LITX_MASK, OP_OR_LIT)) begin
         o_dec.op = ALU_OR; o_dec.use_lit = 1'b1; o_dec.to_acc = 1'b1;
         o_dec.upd_z = 1'b1;
      end else if (hit(i_instr, LIT_MASK, OP_LOAD_LIT)) begin
         o_dec.op = ALU_PASS_K; o_dec.to_acc = 1'b1;
      end else if (hit(i_instr, JUMP_MASK, OP_JUMP)) begin
         o_dec.jump = 1'b1;
      end else if (hit(i_instr, BIT_MASK, OP_BITCLR)) begin
         o_dec.op = ALU_BITCLR; o_dec.to_reg = 1'b1;
      end else if (hit(i_instr, BIT_MASK, OP_BITSET)) begin
         o_dec.op = ALU_BITSET; o_dec.to_reg = 1'b1;
      end else if (hit(i_instr, BIT_MASK, OP_BITTEST)) begin
         o_dec.skip_bit = 1'b1;
      end else if (hit(i_instr, STORE_MASK, OP_STORE)) begin
         o_dec.store = 1'b1; o_dec.to_reg = 1'b1;
      end else if (hit(i_instr, OP_ADD_ACC_AND_REGISTER_MASK, OP_ADD_REG)) begin
         o_dec.op = ALU_ADD; o_dec.to_reg = d; o_dec.to_acc = !d;
         o_dec.upd_z = 1'b1; o_dec.upd_cdc = 1'b1;
      end else if (hit(i_instr, OP_ADD_ACC_AND_REGISTER_MASK, OP_AND_REG)) begin
         o_dec.op = ALU_AND; o_dec.to_reg = d; o_dec.to_acc = !d;
         o_dec.upd_z = 1'b1;
      end else if (hit(i_instr, OP_ADD_ACC_AND_REGISTER_MASK, OP_OR_REG)) begin
         o_dec.op = ALU_OR; o_dec.to_reg = d; o_dec.to_acc = !d;
         o_dec.upd_z = 1'b1;
      end else if (hit(i_instr, OP_ADD_ACC_AND_REGISTER_MASK, OP_MOVE_REG)) begin
         o_dec.op = ALU_PASS_F; o_dec.to_reg = d; o_dec.to_acc = !d;
         o_dec.upd_z = 1'b1;
      end else if (hit(i_instr, OP_ADD_ACC_AND_REGISTER_MASK, OP_INC_REG)) begin
         o_dec.op = ALU_INC; o_dec.to_reg = d; o_dec.to_acc = !d;
         o_dec.upd_z = 1'b1;
      end else if (hit(i_instr, OP_ADD_ACC_AND_REGISTER_MASK, OP_DECSKIP)) begin
         o_dec.op = ALU_DEC; o_dec.to_reg = d; o_dec.to_acc = !d;
         o_dec.skip_zero = 1'b1;
      end else if (hit(i_instr, OP_ADD_ACC_AND_REGISTER_MASK, OP_INCSKIP)) begin
         o_dec.op = ALU_INC; o_dec.to_reg = d; o_dec.to_acc = !d;
         o_dec.skip_zero = 1'b1;
      end
   end

endmodule : instr_decode

// ### byte_alu.sv
// eight-bit arithmetic and logic unit with carry, half carry and zero
`timescale 1ns/1ps
module byte_alu
   import byte_core_pkg::*;
(
   input  wire alu_op_t    i_op,     // operation select
   input  wire logic [7:0] i_a,      // accumulator operand
   input  wire logic [7:0] i_b,      // register or immediate operand
   input  wire logic [2:0] i_bitsel, // bit position for bit ops
   output logic [7:0]      o_res,    // eight-bit result
   output flags_t          o_flags   // flags from this result
);

   // result and flags; zero from any result, carries from the add
   always_comb begin
      logic [8:0] sum;
      logic [4:0] low;
      sum = {1'b0, i_a} + {1'b0, i_b};
      low = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
      case (i_op)
         ALU_ADD:    o_res = sum[7:0];
         ALU_AND:    o_res = i_a & i_b;
         ALU_OR:     o_res = i_a | i_b;
         ALU_PASS_F: o_res = i_b;
         ALU_PASS_K: o_res = i_b;
         ALU_INC:    o_res = i_b + 8'h01;
         ALU_DEC:    o_res = i_b - 8'h01;
         ALU_BITCLR: o_res = i_b & ~(8'h01 << i_bitsel);
         ALU_BITSET: o_res = i_b | (8'h01 << i_bitsel);
         default:    o_res = i_a;
      endcase
      o_flags.z               = (o_res == 8'h00);
      o_flags.c               = sum[8];
      o_flags.half_carry_flag = low[4];
   end

endmodule : byte_alu

// ### byte_core_execute.sv
// execute stage: one instruction per four-clock cycle, skips and jumps
// Function
// - add immediate to accumulator, result in accumulator, carry, half carry, zero updated.
// - add accumulator and register, destination bit picks target, all three flags.
// - and immediate with accumulator into accumulator, only zero flag changes.
// - and accumulator with register into chosen destination, only zero changes.
// - clear chosen bit of register, other bits kept, no flag changes.
// - set chosen bit of register, other bits kept, no flag changes.
// - bit test: clear bit turns next instruction into no-operation, two cycles.
// - decrement register to destination; zero result skips next; no flags.
// - increment register to destination; zero result skips next; no flags.
// - increment register into destination chosen by bit, zero flag updated.
// - jump loads 11 bits of counter; top two from latch bits 4..3; two cycles.
// - or immediate with accumulator into accumulator, only zero flag changes.
// - or accumulator with register into chosen destination, only zero changes.
// - move register to accumulator or itself, zero flag updated, one cycle.
// - store accumulator into register, no flag changes, one cycle.
// - load immediate into accumulator, no flag changes.
`timescale 1ns/1ps
module byte_core_execute
   import byte_core_pkg::*;
#(
   parameter int CYCLE_CLKS = CLKS_PER_CYCLE  // clocks per instruction cycle
)(
   input  wire logic        i_clk,        // core clock, 10 MHz
   input  wire logic        i_rst,        // asynchronous reset, active high
   input  wire logic [13:0] i_instr,      // instruction word from program memory
   input  wire logic [7:0]  i_reg_rdata,  // register file read data at o_reg_raddr
   input  wire logic [7:0]  i_pc_hi_latch,// program_counter_high_latch contents
   output logic [12:0]      o_pc,         // fetch address
   output logic [6:0]       o_reg_raddr,  // register file read address
   output reg_wr_t          o_reg_wr,     // register write, one-clock pulse
   output logic [7:0]       o_acc,        // accumulator
   output flags_t           o_flags,      // status flags
   output logic             o_cycle_end   // one-clock pulse at end of each cycle
);

   initial begin
      if (CYCLE_CLKS < 2 || CYCLE_CLKS > 16)
         $error("CYCLE_CLKS out of range");
   end

   dec_t       dec;
   logic [7:0] alu_res;
   flags_t     alu_flags;
   logic [7:0] b_opnd;

   instr_decode u_dec (
      .i_instr (i_instr),
      .o_dec   (dec)
   );

   // b operand: immediate or the addressed register
   assign b_opnd = (dec.use_lit || dec.op == ALU_PASS_K) ? dec.lit : i_reg_rdata;

   byte_alu u_alu (
      .i_op     (dec.op),
      .i_a      (o_acc),
      .i_b      (b_opnd),
      .i_bitsel (dec.bitsel),
      .o_res    (alu_res),
      .o_flags  (alu_flags)
   );

   // phase counter divides the clock into instruction cycles
   logic [3:0] phase_ff, nxt_phase;
   logic       exec_en;

   always_comb begin
      exec_en   = (phase_ff == 4'(CYCLE_CLKS - 1));
      nxt_phase = exec_en ? 4'h0 : phase_ff + 4'h1;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         phase_ff <= 4'h0;
      end else begin
         phase_ff <= nxt_phase;
      end
   end

   // sequencing of the execute cycle
   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_FLUSH = 2'b01,
      ST_JUMP  = 2'b10
   } exec_state_t;

   exec_state_t state_ff, nxt_state;
   logic [12:0] pc_ff, nxt_pc;
   logic [7:0]  acc_ff, nxt_acc;
   flags_t      flags_ff, nxt_flags;
   reg_wr_t     wr_ff, nxt_wr;
   logic        end_ff, nxt_end;

   // next-state logic; work happens only on the cycle enable
   always_comb begin
      logic take_skip;
      logic do_exec;
      take_skip = 1'b0;
      do_exec   = 1'b0;
      nxt_state = state_ff;
      nxt_pc    = pc_ff;
      nxt_acc   = acc_ff;
      nxt_flags = flags_ff;
      nxt_wr    = '0;
      nxt_end   = exec_en;
      if (exec_en) begin
         case (state_ff)
            ST_FLUSH: begin
               // discarded word runs as a no-operation
               nxt_state = ST_RUN;
               nxt_pc    = pc_ff + 13'h0001;
            end
            ST_JUMP: begin
               // target word is fetched during this idle cycle and runs next
               nxt_state = ST_RUN;
            end
            ST_RUN: begin
               do_exec = 1'b1;
            end
            default: begin
               nxt_state = ST_RUN;
            end
         endcase
      end
      if (do_exec) begin
         if (dec.jump) begin
            // new address; one idle cycle while the target word is fetched
            nxt_pc    = {i_pc_hi_latch[HI_LATCH_LSB+1:HI_LATCH_LSB], dec.target};
            nxt_state = ST_JUMP;
         end else begin
            nxt_pc = pc_ff + 13'h0001;
            if (dec.skip_zero && alu_res == 8'h00)
               take_skip = 1'b1;
            if (dec.skip_bit && !i_reg_rdata[dec.bitsel])
               take_skip = 1'b1;
            if (take_skip)
               nxt_state = ST_FLUSH;
            if (dec.to_acc)
               nxt_acc = alu_res;
            if (dec.to_reg) begin
               nxt_wr.en   = 1'b1;
               nxt_wr.addr = dec.faddr;
               nxt_wr.data = dec.store ? acc_ff : alu_res;
            end
            if (dec.upd_z)
               nxt_flags.z = alu_flags.z;
            if (dec.upd_cdc) begin
               nxt_flags.c               = alu_flags.c;
               nxt_flags.half_carry_flag = alu_flags.half_carry_flag;
            end
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_ff <= ST_RUN;
         pc_ff    <= PC_RST;
         acc_ff   <= ACC_RST;
         flags_ff <= '0;
         wr_ff    <= '0;
         end_ff   <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         pc_ff    <= nxt_pc;
         acc_ff   <= nxt_acc;
         flags_ff <= nxt_flags;
         wr_ff    <= nxt_wr;
         end_ff   <= nxt_end;
      end
   end

   // read address follows the word currently held
   logic [6:0] raddr_ff, nxt_raddr;

   always_comb begin
      nxt_raddr = i_instr[6:0];
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         raddr_ff <= 7'h00;
      end else begin
         raddr_ff <= nxt_raddr;
      end
   end

   // outputs straight from flip-flops
   assign o_pc        = pc_ff;
   assign o_acc       = acc_ff;
   assign o_flags     = flags_ff;
   assign o_reg_wr    = wr_ff;
   assign o_cycle_end = end_ff;
   assign o_reg_raddr = raddr_ff;

endmodule : byte_core_execute

// ### byte_core_execute_asserts.sv
// concurrent checks on the ports of the instruction execute block
`timescale 1ns/1ps
module byte_core_execute_asserts
   import byte_core_pkg::*;
#(
   parameter int CYCLE_CLKS = CLKS_PER_CYCLE  // clocks per instruction cycle
)(
   input  wire logic        i_clk,         // core clock
   input  wire logic        i_rst,         // async reset
   input  wire logic [13:0] i_instr,       // fetched word
   input  wire logic [7:0]  i_reg_rdata,   // register read data
   input  wire logic [7:0]  i_pc_hi_latch, // high latch
   input  wire logic [12:0] o_pc,          // fetch address
   input  wire logic [6:0]  o_reg_raddr,   // read address
   input  wire reg_wr_t     o_reg_wr,      // register write
   input  wire logic [7:0]  o_acc,         // accumulator
   input  wire flags_t      o_flags,       // flags
   input  wire logic        o_cycle_end    // cycle pulse
);
   logic [13:0] ins_ff;
   logic [7:0]  rd_ff;
   logic [7:0]  lat_ff;
   logic [7:0]  acc_ff;
   logic [3:0]  cnt_ff;
   logic        flush_ff;
   logic        jump_ff;
   logic        seen_ff;
   logic [7:0]  bmask;
   logic        taken;
   logic        live;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // skip or jump decided by the word held from the execute edge
   assign bmask = 8'h01 << ins_ff[9:7];
   assign taken = ((ins_ff & JUMP_MASK) == OP_JUMP)
                  || ((ins_ff & OP_ADD_ACC_AND_REGISTER_MASK) == OP_DECSKIP && rd_ff == 8'h01)
                  || ((ins_ff & OP_ADD_ACC_AND_REGISTER_MASK) == OP_INCSKIP && rd_ff == 8'hFF)
                  || ((ins_ff & BIT_MASK) == OP_BITTEST && (rd_ff & bmask) == 8'h00);
   assign live  = o_cycle_end && !flush_ff;
   // operands seen at each edge, flush tracking, cycle spacing count
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ins_ff   <= 14'h0000;
         rd_ff    <= 8'h00;
         lat_ff   <= 8'h00;
         acc_ff   <= 8'h00;
         cnt_ff   <= 4'h0;
         flush_ff <= 1'b0;
         jump_ff  <= 1'b0;
         seen_ff  <= 1'b0;
      end else begin
         ins_ff <= i_instr;
         rd_ff  <= i_reg_rdata;
         lat_ff <= i_pc_hi_latch;
         acc_ff <= o_acc;
         if (o_cycle_end) begin
            flush_ff <= live && taken;
            jump_ff  <= live && (ins_ff & JUMP_MASK) == OP_JUMP;
            seen_ff  <= 1'b1;
            cnt_ff   <= 4'h0;
         end else if (cnt_ff != 4'hF) begin
            cnt_ff <= cnt_ff + 4'h1;
         end
      end
   end
   load_imm_a: assert property (live && (ins_ff & LIT_MASK) == OP_LOAD_LIT
      |-> o_acc == ins_ff[7:0] && $stable(o_flags)) else $error("load immediate wrong");
   add_imm_a: assert property (live && (ins_ff & ADD_LIT_MASK) == OP_ADD_LIT
      |-> o_acc == 8'(acc_ff + ins_ff[7:0]) && o_flags.z == (o_acc == 8'h00)
      && o_flags.c == ((9'(acc_ff) + 9'(ins_ff[7:0])) > 9'h0FF)
      && o_flags.half_carry_flag == ((5'(acc_ff[3:0]) + 5'(ins_ff[3:0])) > 5'h0F)) else $error("add immediate wrong");
   bit_clear_a: assert property (live && (ins_ff & BIT_MASK) == OP_BITCLR
      |-> o_reg_wr.en && o_reg_wr.addr == ins_ff[6:0] && o_reg_wr.data == (rd_ff & ~bmask)
      && $stable(o_flags)) else $error("bit clear wrong");
   bit_set_a: assert property (live && (ins_ff & BIT_MASK) == OP_BITSET
      |-> o_reg_wr.en && o_reg_wr.addr == ins_ff[6:0] && o_reg_wr.data == (rd_ff | bmask)
      && $stable(o_flags)) else $error("bit set wrong");
   store_acc_a: assert property (live && (ins_ff & STORE_MASK) == OP_STORE
      |-> o_reg_wr.en && o_reg_wr.addr == ins_ff[6:0] && o_reg_wr.data == acc_ff
      && o_acc == acc_ff && $stable(o_flags)) else $error("store wrong");
   jump_target_a: assert property (live && (ins_ff & JUMP_MASK) == OP_JUMP
      |-> o_pc == {lat_ff[4:3], ins_ff[10:0]} && $stable(o_flags)) else $error("jump target wrong");
   pc_step_a: assert property (live && (ins_ff & JUMP_MASK) != OP_JUMP
      |-> o_pc == $past(o_pc) + 13'h1) else $error("counter step wrong");
   flush_idle_a: assert property (o_cycle_end && flush_ff
      |-> !o_reg_wr.en && o_acc == acc_ff && $stable(o_flags)
      && o_pc == $past(o_pc) + (jump_ff ? 13'h0 : 13'h1)) else $error("flush cycle changed state");
   raddr_track_a: assert property (seen_ff
      |-> o_reg_raddr == $past(i_instr[6:0])) else $error("read address wrong");
   and_dest_a: assert property (live && (ins_ff & OP_ADD_ACC_AND_REGISTER_MASK) == OP_AND_REG
      |-> (ins_ff[7] ? (o_reg_wr.en && o_reg_wr.data == (acc_ff & rd_ff))
      : (!o_reg_wr.en && o_acc == (acc_ff & rd_ff)))) else $error("and register wrong");
   dec_skip_a: assert property (live && (ins_ff & OP_ADD_ACC_AND_REGISTER_MASK) == OP_DECSKIP
      |-> (ins_ff[7] ? o_reg_wr.data == 8'(rd_ff - 8'h01) : o_acc == 8'(rd_ff - 8'h01))
      && $stable(o_flags)) else $error("decrement skip wrong");
   cycle_space_a: assert property (seen_ff
      |-> o_cycle_end == (cnt_ff == CYCLE_CLKS - 1)) else $error("cycle spacing wrong");
endmodule : byte_core_execute_asserts

// ### prog_reg_model.sv
// program memory and data register file facing the execute block
`timescale 1ns/1ps
module prog_reg_model
   import byte_core_pkg::*;
(
   input  wire logic        i_clk,   // core clock
   input  wire logic [12:0] i_pc,    // fetch address
   input  wire reg_wr_t     i_wr,    // register write pulse
   output logic [13:0]      o_instr, // word at the fetch address
   output logic [7:0]       o_rdata  // register named by the word
);
   logic [13:0] prog [0:8191];
   logic [7:0]  regs [0:127];
   // combinational fetch and register read
   assign o_instr = prog[i_pc];
   assign o_rdata = regs[o_instr[6:0]];
   // write lands on the clock that ends the pulse
   always @(posedge i_clk) begin
      if (i_wr.en)
         regs[i_wr.addr] <= i_wr.data;
   end
endmodule : prog_reg_model

// ### tb_top.sv
// self-checking bench for the instruction execute block
`timescale 1ns/1ps
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top
   import byte_core_pkg::*;
;
   localparam int CYC = 4;
   localparam logic [13:0] BASES [15] = '{OP_ADD_LIT, OP_AND_LIT, OP_OR_LIT, OP_LOAD_LIT, OP_ADD_REG,
      OP_AND_REG, OP_OR_REG, OP_MOVE_REG, OP_INC_REG, OP_DECSKIP, OP_INCSKIP, OP_BITCLR, OP_BITSET,
      OP_BITTEST, OP_STORE};
   logic        i_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic [7:0]  lat   = 8'h00;
   logic [13:0] instr;
   logic [7:0]  rdata;
   logic [12:0] fetch_pc;
   reg_wr_t     wr;
   logic [7:0]  acc_o;
   flags_t      flags_o;
   logic        cyc_end;
   logic [23:0] notes [$];
   logic [23:0] exp_n;
   logic [7:0]  acc = 8'h00;
   logic [7:0]  regs [0:127];
   logic        z = 1'b0;
   logic        dc = 1'b0;
   logic        c = 1'b0;
   logic [12:0] pc = 13'h0000;
   int          bad_count = 0;
   int          n_compared = 0;
   int          cycles = 0;
   int          seed = 32'h1485e455;
   always #50 i_clk = ~i_clk;
   byte_core_execute #(.CYCLE_CLKS(CYC)) byte_core_execute_inst (.i_clk(i_clk), .i_rst(i_rst),
      .i_instr(instr), .i_reg_rdata(rdata), .i_pc_hi_latch(lat), .o_pc(fetch_pc), .o_reg_raddr(),
      .o_reg_wr(wr), .o_acc(acc_o), .o_flags(flags_o), .o_cycle_end(cyc_end));
   prog_reg_model prog_reg_model_inst (.i_clk(i_clk), .i_pc(fetch_pc), .i_wr(wr), .o_instr(instr),
      .o_rdata(rdata));
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   // reference execution of one word placed at the model counter
   task automatic step(input logic [13:0] w);
      logic [7:0] v;
      logic [7:0] o;
      logic [7:0] m;
      logic [7:0] r;
      logic [4:0] ctl;
      logic [8:0] s;
      logic [4:0] h;
      v = regs[w[6:0]];
      o = w[13] ? w[7:0] : v;
      m = 8'h01 << w[9:7];
      prog_reg_model_inst.prog[pc] = w;
      // ctl: destination reg, destination acc, zero, carries, skip
      casez (w)
         14'b11111?????????: {ctl, r} = {5'h0E, 8'(acc + o)};
         14'b111001????????: {ctl, r} = {5'h0C, acc & o};
         14'b111000????????: {ctl, r} = {5'h0C, acc | o};
         14'b1100??????????: {ctl, r} = {5'h08, o};
         14'b0100??????????: {ctl, r} = {5'h10, v & ~m};
         14'b0101??????????: {ctl, r} = {5'h10, v | m};
         14'b0110??????????: {ctl, r} = {4'h0, (v & m) == 8'h00, 8'h00};
         14'b0000001???????: {ctl, r} = {5'h10, acc};
         14'b000111????????: {ctl, r} = {w[7], ~w[7], 3'h6, 8'(acc + o)};
         14'b000101????????: {ctl, r} = {w[7], ~w[7], 3'h4, acc & o};
         14'b000100????????: {ctl, r} = {w[7], ~w[7], 3'h4, acc | o};
         14'b001000????????: {ctl, r} = {w[7], ~w[7], 3'h4, v};
         14'b001010????????: {ctl, r} = {w[7], ~w[7], 3'h4, 8'(v + 8'h01)};
         14'b001011????????: {ctl, r} = {w[7], ~w[7], 2'h0, v == 8'h01, 8'(v - 8'h01)};
         14'b001111????????: {ctl, r} = {w[7], ~w[7], 2'h0, v == 8'hFF, 8'(v + 8'h01)};
         default:            {ctl, r} = 13'h0000;
      endcase
      s = {1'b0, acc} + {1'b0, o};
      h = {1'b0, acc[3:0]} + {1'b0, o[3:0]};
      if (ctl[1]) {c, dc} = {s[8], h[4]};
      if (ctl[2]) z = (r == 8'h00);
      if (ctl[4]) regs[w[6:0]] = r;
      if (ctl[3]) acc = r;
      pc = (w[13:11] == 3'b101) ? {lat[4:3], w[10:0]} : pc + 13'h1;
      notes.push_back({acc, z, dc, c, pc});
      // skip: discarded word is a load that would show; jump: idle cycle holds target
      if (w[13:11] == 3'b101 || ctl[0]) begin
         if (ctl[0]) begin
            prog_reg_model_inst.prog[pc] = 14'h30EE;
            pc = pc + 13'h1;
         end
         notes.push_back({acc, z, dc, c, pc});
      end
   endtask : step
   // each finished cycle against the oldest note
   always @(negedge i_clk) begin
      cycles++;
      if (cycles > 3000) begin
         bad_count++;
         give_verdict();
      end else if (cyc_end && notes.size() > 0) begin
         exp_n = notes.pop_front();
         `CHECK({acc_o, flags_o, fetch_pc}, exp_n)
      end
   end
   // program build, reset, run and register file sweep
   initial begin
      lat = (8'($random(seed)) & 8'hE7) | 8'h10;
      for (int i = 0; i < 8192; i++) prog_reg_model_inst.prog[i] = 14'h0000;
      for (int i = 0; i < 128; i++) begin
         regs[i] = 8'($random(seed));
         prog_reg_model_inst.regs[i] = regs[i];
      end
      step(14'h300F);
      step(14'h3E01);
      step(14'h30FF);
      step(14'h3E01);
      step(14'h3001);
      step(14'h0085);
      step(14'h0B85);
      step(14'h30FF);
      step(14'h0086);
      step(14'h0F06);
      step(14'h1187);
      step(14'h1987);
      step(14'h1587);
      step(14'h1987);
      step(14'h30A5);
      step(14'h390F);
      step(14'h3830);
      step(14'h0A87);
      step(14'h0487);
      step(14'h0807);
      for (int j = 0; j < 2; j++) begin
         step(14'h2800 | (j == 0 ? 14'h0000 : 14'h0600) | (14'($random(seed)) & 14'h00FF));
         for (int i = 0; i < 45; i++)
            step(BASES[i % 15] | (14'($random(seed)) & (i % 15 > 10 ? (i % 15 == 14 ? 14'h007F : 14'h03FF)
               : 14'h00FF)));
      end
      repeat (6) @(posedge i_clk);
      #1 i_rst = 1'b0;
      while (notes.size() > 0) @(posedge i_clk);
      repeat (8) @(posedge i_clk);
      for (int i = 0; i < 128; i++)
         `CHECK(prog_reg_model_inst.regs[i], regs[i])
      give_verdict();
   end
endmodule : tb_top
bind byte_core_execute byte_core_execute_asserts #(.CYCLE_CLKS(CYCLE_CLKS)) byte_core_execute_asserts_inst (
   .i_clk(i_clk), .i_rst(i_rst), .i_instr(i_instr), .i_reg_rdata(i_reg_rdata), .i_pc_hi_latch(i_pc_hi_latch),
   .o_pc(o_pc), .o_reg_raddr(o_reg_raddr), .o_reg_wr(o_reg_wr), .o_acc(o_acc), .o_flags(o_flags),
   .o_cycle_end(o_cycle_end));
